// File: hdl/wdrs_device.sv
// Watchdog timer, stop recovery and reset supervisor
// Overview of operation
// - Either recovery register event ends stop
// - Output pins excluded from wake equations
// - Retriggerable one-shot resets at terminal count
// - First instruction arms, later ones refresh
// - Instruction updates zero, sign, overflow flags
// - Bit 4 picks RC or crystal clock
// - RC time-outs 5, 10, 20, 80 ms
// - Crystal time-outs 256 to 4096 periods
// - Time select defaults to code 01
// - Bit 2 keeps counting in halt
// - Bit 3 keeps counting in stop
// - Software picks RC clock for stop
// - Mode writes only within 60 cycles
// - Later mode writes ignored until reset
// - Mode register write-only at 0FH
// - Bits 5 to 7 have no effect
// - Low voltage holds global reset
// - Low-voltage flag valid after 20 us
// - Software disables detection before stop
// - Clear rising edge starts reset timers
// - Time-out triggers reset one-shot of 5000 chain-clock ticks, 5 ms on RC
// - Warm flag set on stop wake
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "wdrs_params.svh"
module wdrs_device
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Oscillator ticks from outside this domain
  input wire logic rc_osc_in,
  input wire logic crystal_input_pin_in,
  // Supply and clear inputs
  input wire logic low_voltage_in,
  input wire logic clear_input_one_in,
  input wire logic clear_input_two_in,
  // Recovery source select, software side
  input wire wdrs_pkg::wdrs_byte_t stop_recovery_select_in,
  // Core side
  wdrs_if.dev bus
);
  import wdrs_pkg::*;

  typedef struct packed {
    logic [2:0] rc_s;
    logic [2:0] xt_s;
    logic [2:0] lv_s;
    logic [2:0] c1_s;
    logic [2:0] c2_s;
    logic [7:0] wmode;
    logic [7:0] srs2;
    logic [7:0] win;
    logic armed;
    logic [23:0] cnt;
    logic tc;
    logic tc_s1;
    logic tc_s2;
    logic [23:0] por_cnt;
    logic [4:0] rst_cnt;
    logic [10:0] lvd_cnt;
    logic lvd_valid;
    logic lvd_flag;
    logic warm;
    logic reset_n;
    logic fz;
    logic fs;
    logic fv;
    logic fstb;
    logic [7:0] p2_s0;
    logic [7:0] p2_s1;
    logic [7:0] p2_s2;
    logic [7:0] p2_f;
  } wdrs_state_s;

  wdrs_state_s s_reg, s_next;

  // Time-out in counter ticks from time select and clock source
  function automatic logic [23:0] wdrs_limit(input logic [7:0] m);
    logic [23:0] r;
    r = 24'h00_0000;
    if (m[`WDRS_BIT_CLK])
    begin
      unique case (m[1:0])
        2'b00: r = 24'(`WDRS_TO_XT0);
        2'b01: r = 24'(`WDRS_TO_XT1);
        2'b10: r = 24'(`WDRS_TO_XT2);
        2'b11: r = 24'(`WDRS_TO_XT3);
      endcase
    end
    else
    begin
      unique case (m[1:0])
        2'b00: r = 24'(`WDRS_TO_RC0_MS * 1000);
        2'b01: r = 24'(`WDRS_TO_RC1_MS * 1000);
        2'b10: r = 24'(`WDRS_TO_RC2_MS * 1000);
        2'b11: r = 24'(`WDRS_TO_RC3_MS * 1000);
      endcase
    end
    return r;
  endfunction

  // Wake source decode, shared by both select registers
  function automatic logic wdrs_wake(input logic [2:0] src, input logic [7:0] p, input logic [7:0] po,
    input logic hi);
    logic [7:0] act;
    logic w;
    act = (hi ? p : ~p) & ~po;
    w = 1'b0;
    unique case (src)
      3'b101: w = act[7];
      3'b110: w = |act[3:0];
      3'b111: w = |act;
      default: w = 1'b0;
    endcase
    return w;
  endfunction

  logic rc_tick, xt_tick, tick, wake, stop_mode, count_en, c_rise;
  logic [23:0] limit;

  always_comb
  begin
    // Rising edge counted when stage two is high and stage three still low
    rc_tick = s_reg.rc_s[1] & ~s_reg.rc_s[2];
    xt_tick = s_reg.xt_s[1] & ~s_reg.xt_s[2];
    tick = s_reg.wmode[`WDRS_BIT_CLK] ? xt_tick : rc_tick;
    limit = wdrs_limit(s_reg.wmode);
    stop_mode = (bus.cpu_mode == WDRS_STOP);
    // Either register's event wakes the part
    wake = stop_mode & (wdrs_wake(stop_recovery_select_in[4:2], s_reg.p2_f, bus.port2_is_out,
      stop_recovery_select_in[6]) | wdrs_wake(s_reg.srs2[4:2], s_reg.p2_f, bus.port2_is_out,
      s_reg.srs2[6]));
    count_en = s_reg.armed & (bus.cpu_mode == WDRS_RUN
      | (bus.cpu_mode == WDRS_HALT & s_reg.wmode[`WDRS_BIT_HALT])
      | (stop_mode & s_reg.wmode[`WDRS_BIT_STOP]));
    c_rise = (s_reg.c1_s[1] & ~s_reg.c1_s[2]) | (s_reg.c2_s[1] & ~s_reg.c2_s[2]);
  end

  // Next state
  always_comb
  begin
    s_next = s_reg;
    s_next.rc_s = {s_reg.rc_s[1:0], rc_osc_in};
    s_next.xt_s = {s_reg.xt_s[1:0], crystal_input_pin_in};
    s_next.lv_s = {s_reg.lv_s[1:0], low_voltage_in};
    s_next.c1_s = {s_reg.c1_s[1:0], clear_input_one_in};
    s_next.c2_s = {s_reg.c2_s[1:0], clear_input_two_in};
    // Port pins are asynchronous: a bit moves only once stages two and three agree
    s_next.p2_s0 = bus.port2_in;
    s_next.p2_s1 = s_reg.p2_s0;
    s_next.p2_s2 = s_reg.p2_s1;
    s_next.p2_f = (s_reg.p2_s1 & s_reg.p2_s2) | (s_reg.p2_f & (s_reg.p2_s1 | s_reg.p2_s2));
    s_next.fstb = 1'b0;
    s_next.tc = 1'b0;
    // Window counts system cycles after reset release
    if (s_reg.reset_n && s_reg.win != `WDRS_CFG_WINDOW)
      s_next.win = s_reg.win + 8'h01;
    if (bus.wr_en && s_reg.reset_n && s_reg.win != `WDRS_CFG_WINDOW)
    begin
      // Reserved upper bits kept but never decoded
      if (bus.wr_addr == `WDRS_OFF_WMODE)
        s_next.wmode = bus.wr_data;
      if (bus.wr_addr == `WDRS_OFF_SRS2)
        s_next.srs2 = bus.wr_data;
    end
    // Instruction arms or refreshes and posts flags
    if (bus.wdt_exec && s_reg.reset_n)
    begin
      s_next.armed = 1'b1;
      s_next.cnt = 24'h00_0000;
      s_next.fz = 1'b0;
      s_next.fs = 1'b0;
      s_next.fv = 1'b0;
      s_next.fstb = 1'b1;
    end
    else if (count_en && tick)
    begin
      if (s_reg.cnt + 24'h00_0001 >= limit)
        s_next.tc = 1'b1;
      else
        s_next.cnt = s_reg.cnt + 24'h00_0001;
    end
    // Two-stage carry into reset logic
    s_next.tc_s1 = s_reg.tc;
    s_next.tc_s2 = s_reg.tc_s1;
    // One-shot and short reset timer
    if (s_reg.tc_s2 || c_rise || wake)
    begin
      s_next.por_cnt = 24'(`WDRS_POR_MS * 1000);
      s_next.rst_cnt = 5'(`WDRS_RST_CLKS);
      s_next.reset_n = 1'b0;
      s_next.armed = 1'b0;
      s_next.cnt = 24'h00_0000;
      s_next.win = 8'h00;
      if (stop_mode)
        s_next.warm = 1'b1;
      else
        s_next.warm = 1'b0;
    end
    else if (s_reg.por_cnt != 24'h00_0000)
    begin
      // One-shot shares the chain clock picked by the mode register
      if (tick)
        s_next.por_cnt = s_reg.por_cnt - 24'h00_0001;
    end
    else if (s_reg.rst_cnt != 5'h00)
      s_next.rst_cnt = s_reg.rst_cnt - 5'h01;
    else
      s_next.reset_n = 1'b1;
    // Low supply overrides everything; its end restarts the timers as a power-on would
    if (s_reg.lv_s[2] && s_reg.lv_s[1])
    begin
      s_next.reset_n = 1'b0;
      s_next.por_cnt = 24'(`WDRS_POR_MS * 1000);
      s_next.rst_cnt = 5'(`WDRS_RST_CLKS);
      s_next.win = 8'h00;
      s_next.armed = 1'b0;
      s_next.warm = 1'b0;
    end
    // Flag valid only after detection is enabled long enough
    if (!bus.lvd_enable)
    begin
      s_next.lvd_cnt = 11'h000;
      s_next.lvd_valid = 1'b0;
    end
    else if (s_reg.lvd_cnt != 11'(`WDRS_LVD_CYC))
      s_next.lvd_cnt = s_reg.lvd_cnt + 11'h001;
    else
      s_next.lvd_valid = 1'b1;
    s_next.lvd_flag = bus.lvd_enable & s_reg.lv_s[2];
  end

  // State register, synchronous reset
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s_reg <= '0;
      s_reg.wmode <= `WDRS_WMODE_RESET;
      s_reg.srs2 <= `WDRS_SRS2_RESET;
      s_reg.por_cnt <= 24'(`WDRS_POR_MS * 1000);
      s_reg.rst_cnt <= 5'(`WDRS_RST_CLKS);
    end
    else
      s_reg <= s_next;
  end

  // Outputs from flip-flops
  assign bus.reset_n = s_reg.reset_n;
  assign bus.flag_z = s_reg.fz;
  assign bus.flag_s = s_reg.fs;
  assign bus.flag_v = s_reg.fv;
  assign bus.flag_strobe = s_reg.fstb;
  assign bus.lvd_valid = s_reg.lvd_valid;
  assign bus.lvd_flag = s_reg.lvd_flag;
  assign bus.warm_flag = s_reg.warm;
endmodule

// File: pkg/wdrs_params.svh
// Constants for the watchdog and reset supervisor
`ifndef WDRS_PARAMS_SVH
`define WDRS_PARAMS_SVH
`define WDRS_OFF_SRS2 8'h0D
`define WDRS_OFF_WMODE 8'h0F
`define WDRS_BIT_HALT 2
`define WDRS_BIT_STOP 3
`define WDRS_BIT_CLK 4
`define WDRS_WMODE_RESET 8'h0D
`define WDRS_SRS2_RESET 8'h00
`define WDRS_CFG_WINDOW 8'h3C
`define WDRS_CLK_MHZ 40
`define WDRS_RC_TICK_NS 1000
`define WDRS_RC_TICK_CYC ((`WDRS_RC_TICK_NS * `WDRS_CLK_MHZ) / 1000)
`define WDRS_TO_RC0_MS 5
`define WDRS_TO_RC1_MS 10
`define WDRS_TO_RC2_MS 20
`define WDRS_TO_RC3_MS 80
`define WDRS_TO_XT0 256
`define WDRS_TO_XT1 512
`define WDRS_TO_XT2 1024
`define WDRS_TO_XT3 4096
`define WDRS_POR_MS 5
`define WDRS_RST_CLKS 18
`define WDRS_LVD_US 20
`define WDRS_LVD_CYC (`WDRS_LVD_US * `WDRS_CLK_MHZ)
`define WDRS_WARM_BIT 7
`endif

// File: pkg/wdrs_pkg.sv
// Types for the watchdog and reset supervisor
package wdrs_pkg;
  typedef logic [7:0] wdrs_byte_t;
  typedef enum logic [1:0] {
    WDRS_RUN = 2'b00,
    WDRS_HALT = 2'b01,
    WDRS_STOP = 2'b10
  } wdrs_mode_e;
endpackage

// File: pkg/wdrs_if.sv
// Interface between processor core and watchdog supervisor
`timescale 1ns/1ps
interface wdrs_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wdt_exec;
  logic [1:0] cpu_mode;
  logic [7:0] port2_in;
  logic [7:0] port2_is_out;
  logic lvd_enable;
  logic reset_n;
  logic flag_z;
  logic flag_s;
  logic flag_v;
  logic flag_strobe;
  logic lvd_valid;
  logic lvd_flag;
  logic warm_flag;
  modport dev (input wr_en, wr_addr, wr_data, wdt_exec, cpu_mode, port2_in, port2_is_out, lvd_enable,
    output reset_n, flag_z, flag_s, flag_v, flag_strobe, lvd_valid, lvd_flag, warm_flag);
  modport core (output wr_en, wr_addr, wr_data, wdt_exec, cpu_mode, port2_is_out, lvd_enable,
    input port2_in, reset_n, flag_z, flag_s, flag_v, flag_strobe, lvd_valid, lvd_flag, warm_flag);
endinterface

// File: hdl/wdrs_core.sv
// Core end: AXI4-Lite command registers driving the supervisor
`timescale 1ns/1ps
`include "wdrs_params.svh"
module wdrs_core
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // AXI4-Lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Supervisor side
  wdrs_if.core dev
);
  import wdrs_pkg::*;

  // Own registers: 0x00 command (b0 refresh, b1 lvd enable, b3:2 mode),
  // 0x04 target write {addr,data}, 0x08 port2 outputs, 0x0C status
  typedef struct packed {
    logic aw_h;
    logic [7:0] aw_a;
    logic w_h;
    logic [31:0] w_d;
    logic w_s;
    logic bv;
    logic rv;
    logic [31:0] rd;
    logic [1:0] mode;
    logic lvd_en;
    logic [7:0] p2o;
    logic exec;
    logic wr;
    logic [15:0] wrd;
    logic [2:0] flags;
  } wdrs_core_s;

  wdrs_core_s c_reg, c_next;

  always_comb
  begin
    c_next = c_reg;
    c_next.exec = 1'b0;
    c_next.wr = 1'b0;
    if (awvalid && !c_reg.aw_h)
    begin
      c_next.aw_h = 1'b1;
      c_next.aw_a = awaddr;
    end
    if (wvalid && !c_reg.w_h)
    begin
      c_next.w_h = 1'b1;
      c_next.w_d = wdata;
      // Lane strobe kept with its data; the master may move it once W is taken
      c_next.w_s = wstrb[0];
    end
    // Write performed once address and data both held
    if (c_reg.aw_h && c_reg.w_h && !c_reg.bv)
    begin
      c_next.aw_h = 1'b0;
      c_next.w_h = 1'b0;
      c_next.bv = 1'b1;
      if (c_reg.w_s)
      begin
        unique case (c_reg.aw_a)
          8'h00:
          begin
            c_next.exec = c_reg.w_d[0];
            c_next.lvd_en = c_reg.w_d[1];
            c_next.mode = c_reg.w_d[3:2];
          end
          8'h04:
          begin
            c_next.wr = 1'b1;
            c_next.wrd = c_reg.w_d[15:0];
          end
          8'h08: c_next.p2o = c_reg.w_d[7:0];
          default: c_next.wr = 1'b0;
        endcase
      end
    end
    if (c_reg.bv && bready)
      c_next.bv = 1'b0;
    if (dev.flag_strobe)
      c_next.flags = {dev.flag_v, dev.flag_s, dev.flag_z};
    if (arvalid && !c_reg.rv)
    begin
      c_next.rv = 1'b1;
      // Low-voltage flag masked until valid
      c_next.rd = (araddr == 8'h0C) ? {24'h00_0000, c_reg.flags, dev.warm_flag,
        dev.lvd_valid & dev.lvd_flag, dev.lvd_valid, dev.reset_n, 1'b0} : 32'h0000_0000;
    end
    else if (c_reg.rv && rready)
      c_next.rv = 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      c_reg <= '0;
    else
      c_reg <= c_next;
  end

  assign awready = !c_reg.aw_h;
  assign wready = !c_reg.w_h;
  assign bvalid = c_reg.bv;
  assign bresp = 2'b00;
  assign arready = !c_reg.rv;
  assign rvalid = c_reg.rv;
  assign rdata = c_reg.rd;
  assign rresp = 2'b00;
  assign dev.wr_en = c_reg.wr;
  assign dev.wr_addr = c_reg.wrd[15:8];
  assign dev.wr_data = c_reg.wrd[7:0];
  assign dev.wdt_exec = c_reg.exec;
  assign dev.cpu_mode = c_reg.mode;
  assign dev.port2_is_out = c_reg.p2o;
  assign dev.lvd_enable = c_reg.lvd_en;
endmodule

// File: bench/wdrs_sva.sv
// Concurrent checks on the core-to-supervisor interface
`timescale 1ns/1ps
module wdrs_sva
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Interface signals under watch
  input wire logic wdt_exec,
  input wire logic [1:0] cpu_mode,
  input wire logic lvd_enable,
  input wire logic reset_n,
  input wire logic flag_z,
  input wire logic flag_s,
  input wire logic flag_v,
  input wire logic flag_strobe,
  input wire logic lvd_valid,
  input wire logic warm_flag
);
  logic [15:0] low_cnt;
  logic [11:0] en_cnt;
  logic seen_stop;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // Helper counts: held reset, detection enabled; saturate so a long hold never wraps
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      low_cnt <= 16'h0000;
      en_cnt <= 12'h000;
      seen_stop <= 1'b0;
    end
    else
    begin
      low_cnt <= reset_n ? 16'h0000 : ((low_cnt == 16'hFFFF) ? low_cnt : low_cnt + 16'h0001);
      en_cnt <= !lvd_enable ? 12'h000 : ((en_cnt == 12'hFFF) ? en_cnt : en_cnt + 12'h001);
      seen_stop <= seen_stop | (cpu_mode == 2'b10);
    end
  end

  // Instruction accepted while running, then its flag answer
  sequence s_exec;
    wdt_exec && reset_n;
  endsequence
  sequence s_answer;
    ##[1:3] flag_strobe;
  endsequence

  a_exec_answer: assert property (s_exec |-> s_answer)
    else $error("instruction got no flag update");
  a_strobe_pulse: assert property (flag_strobe |=> !flag_strobe)
    else $error("flag strobe longer than one cycle");
  a_flags_zero: assert property (flag_strobe |-> !flag_z && !flag_s && !flag_v)
    else $error("flags not cleared by instruction");
  a_strobe_cause: assert property (flag_strobe |-> $past(wdt_exec) || $past(wdt_exec, 2) || $past(wdt_exec, 3))
    else $error("flag strobe without instruction");
  a_reset_stretch: assert property ($rose(reset_n) |-> low_cnt >= 16'h0012)
    else $error("reset released too early");
  a_lvd_settle: assert property ($rose(lvd_valid) |-> en_cnt >= 12'h031F)
    else $error("detect flag valid too soon");
  a_lvd_clear: assert property (!lvd_enable [*3] |-> !lvd_valid)
    else $error("detect flag valid while disabled");
  a_cold_start: assert property (!seen_stop |-> !warm_flag)
    else $error("warm flag without stop");
endmodule

// File: bench/wdrs_bench.sv
// Self-checking bench for the core and supervisor pair
`timescale 1ns/1ps
module wdrs_bench;
  import wdrs_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic rc_osc = 1'b0;
  logic xtal = 1'b0;
  logic rc_run = 1'b1;
  logic xt_run = 1'b1;
  logic low_voltage = 1'b0;
  logic [7:0] p2in = 8'hFF;
  logic [7:0] srs = 8'h00;
  logic clear_input_one = 1'b0;
  logic awvalid = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic wvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  int mismatches = 0;
  int comparisons = 0;

  wdrs_if link();
  assign link.port2_in = p2in;

  // Bench clock, 40 MHz
  always #12.5 clk_in = ~clk_in;

  // Oscillators tick every other cycle so long counts stay short in simulation
  always @(posedge clk_in)
  begin
    rc_osc <= rc_run ? ~rc_osc : rc_osc;
    xtal <= xt_run ? ~xtal : xtal;
  end

  wdrs_core u_wdrs_core (.clk_in(clk_in), .resetn_in(resetn_in), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .dev(link));
  wdrs_device u_wdrs_device (.clk_in(clk_in), .resetn_in(resetn_in), .rc_osc_in(rc_osc),
    .crystal_input_pin_in(xtal), .low_voltage_in(low_voltage), .clear_input_one_in(clear_input_one),
    .clear_input_two_in(1'b0), .stop_recovery_select_in(srs), .bus(link));
  wdrs_sva u_wdrs_sva (.clk_in(clk_in), .resetn_in(resetn_in), .wdt_exec(link.wdt_exec),
    .cpu_mode(link.cpu_mode), .lvd_enable(link.lvd_enable), .reset_n(link.reset_n), .flag_z(link.flag_z),
    .flag_s(link.flag_s), .flag_v(link.flag_v), .flag_strobe(link.flag_strobe), .lvd_valid(link.lvd_valid),
    .warm_flag(link.warm_flag));

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Report and end the run
  task automatic give_verdict;
    $display("Mismatches %0d, comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Bounded wait for the supervisor reset line to reach a level
  task automatic settle(input logic lvl, input int lim);
    int n;
    n = 0;
    while (link.reset_n !== lvl && n < lim)
    begin
      @(posedge clk_in);
      n++;
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    // One edge passes so a following call never re-raises bready in the same step
    @(posedge clk_in);
  endtask

  // Read: data taken at the edge where rvalid is sampled
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    // One edge passes so a following call never re-raises rready in the same step
    @(posedge clk_in);
  endtask

  // Main sequence
  initial
  begin
    cycles(4);
    resetn_in <= 1'b1;
    cycles(1);
    check("reset held", link.reset_n, 1'b0);
    settle(1'b1, 12000);
    axi_read(8'h0C, rd);
    check("running", rd[1], 1'b1);
    check("cold start", rd[4], 1'b0);
    // A mode write after the window must not switch to the fast crystal tap
    rc_run <= 1'b0;
    cycles(100);
    axi_write(8'h04, 32'h0000_0F10);
    axi_write(8'h00, 32'h0000_0001);
    axi_read(8'h0C, rd);
    check("flags", rd[7:5], 3'b000);
    cycles(1500);
    check("late write ignored", link.reset_n, 1'b1);
    // Fresh reset, then crystal source with shortest tap and reserved bits set
    resetn_in <= 1'b0;
    rc_run <= 1'b1;
    cycles(4);
    resetn_in <= 1'b1;
    cycles(1);
    settle(1'b1, 12000);
    axi_write(8'h04, 32'h0000_0FF0);
    rc_run <= 1'b0;
    axi_write(8'h00, 32'h0000_0001);
    cycles(400);
    axi_write(8'h00, 32'h0000_0001);
    cycles(400);
    check("refreshed", link.reset_n, 1'b1);
    settle(1'b0, 400);
    check("timed out", link.reset_n, 1'b0);
    rc_run <= 1'b1;
    settle(1'b1, 12000);
    check("recovered", link.reset_n, 1'b1);
    axi_read(8'h0C, rd);
    check("cold after timeout", rd[4], 1'b0);
    // Detection flag settles; watchdog stays idle until armed again
    axi_write(8'h00, 32'h0000_0002);
    cycles(850);
    axi_read(8'h0C, rd);
    check("detect valid", rd[2], 1'b1);
    check("not armed", rd[1], 1'b1);
    low_voltage <= 1'b1;
    cycles(5);
    check("low supply", link.reset_n, 1'b0);
    axi_read(8'h0C, rd);
    check("detect flag", rd[3], 1'b1);
    low_voltage <= 1'b0;
    settle(1'b1, 12000);
    check("supply back", link.reset_n, 1'b1);
    // Window open again: second recovery register waits on pin 7 low
    axi_write(8'h04, 32'h0000_0D14);
    axi_write(8'h08, 32'h0000_0001);
    srs <= 8'h18;
    axi_write(8'h00, 32'h0000_0008);
    // Pin 0 is an output, so its low level must not wake
    p2in <= 8'hFE;
    cycles(20);
    check("output pin ignored", link.reset_n, 1'b1);
    p2in <= 8'h7F;
    cycles(20);
    check("second register wake", link.reset_n, 1'b0);
    axi_read(8'h0C, rd);
    check("warm start", rd[4], 1'b1);
    axi_write(8'h00, 32'h0000_0000);
    p2in <= 8'hFF;
    settle(1'b1, 12000);
    check("wake recovered", link.reset_n, 1'b1);
    // Clear input rise restarts the reset timers
    clear_input_one <= 1'b1;
    cycles(5);
    check("clear restart", link.reset_n, 1'b0);
    axi_read(8'h0C, rd);
    check("cold after clear", rd[4], 1'b0);
    // First register alone wakes: pin 1 is an input
    axi_write(8'h00, 32'h0000_0008);
    p2in <= 8'hFD;
    cycles(20);
    axi_read(8'h0C, rd);
    check("first register wake", rd[4], 1'b1);
    give_verdict;
  end

  // Hang guard, well beyond the expected run length
  initial
  begin
    #2000000;
    mismatches++;
    give_verdict;
  end
endmodule
